// File: src/lshf_pkg.sv
package lshf_pkg;
  // ==========================================================
  // delay defaults, in milliseconds
  localparam int unsigned UP_DELAY_DEF_MS = 200;
  localparam int unsigned DOWN_DELAY_DEF_MS = 0;
  // ==========================================================
  // tick timing: one millisecond tick at the system clock rate
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // ==========================================================
  // delay register width and reset values
  localparam int unsigned DELAY_W = 16;
  localparam logic [15:0] UP_DELAY_RST = 16'h00C8;
  localparam logic [15:0] DOWN_DELAY_RST = 16'h0000;
  // ==========================================================
  // filter states
  typedef enum logic [1:0] {
    LSHF_STABLE,
    LSHF_HOLD_UP,
    LSHF_HOLD_DOWN
  } lshf_state_e;
endpackage

// File: src/lshf_filter.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - raw link rising starts the up hold-off timer with the up delay, or reports up at once when that is zero
// - raw link falling starts the down hold-off timer with the down delay
// - reported state holds its value while a hold-off timer runs, unless signal absence is seen
// - unconfigured delays: up 200 ms, down 0 ms
// - zero down delay passes a falling link on immediately
// - each configuration write replaces both delays; absent ones take default
// - up delay, down delay or both may be configured, in milliseconds
// - signal absence indication bypasses the hold-off entirely
module lshf_filter
  import lshf_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // raw link detector pins
  input wire logic link_raw,
  input wire logic signal_absence_indication,
  // configuration write
  input wire logic cfg_wr,
  input wire logic cfg_up_valid,
  input wire logic [DELAY_W-1:0] cfg_up_ms,
  input wire logic cfg_down_valid,
  input wire logic [DELAY_W-1:0] cfg_down_ms,
  // higher-layer notification
  output logic link_state,
  output logic link_notify,
  output logic [DELAY_W-1:0] up_delay,
  output logic [DELAY_W-1:0] down_delay
);
  // ==========================================================
  // elaboration checks
  if (TICK_CYC < 1) begin : g_chk
    $error("tick period must be at least one cycle");
  end

  // ==========================================================
  // pin synchronisers
  logic [1:0] link_sync_q, link_sync_d;
  logic [1:0] sai_sync_q, sai_sync_d;
  logic link_s, sai_s;

  always_comb begin
    link_sync_d = {link_sync_q[0], link_raw};
    sai_sync_d = {sai_sync_q[0], signal_absence_indication};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link_sync_q <= 2'h0;
      sai_sync_q <= 2'h0;
    end else begin
      link_sync_q <= link_sync_d;
      sai_sync_q <= sai_sync_d;
    end
  end

  assign link_s = link_sync_q[1];
  assign sai_s = sai_sync_q[1];

  // ==========================================================
  // configuration
  logic [DELAY_W-1:0] up_q, up_d, down_q, down_d;

  always_comb begin
    up_d = up_q;
    down_d = down_q;
    if (cfg_wr) begin
      // both always rewritten, so stale values cannot linger
      up_d = cfg_up_valid ? cfg_up_ms : UP_DELAY_RST;
      down_d = cfg_down_valid ? cfg_down_ms : DOWN_DELAY_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      up_q <= UP_DELAY_RST;
      down_q <= DOWN_DELAY_RST;
    end else begin
      up_q <= up_d;
      down_q <= down_d;
    end
  end

  assign up_delay = up_q;
  assign down_delay = down_q;

  // ==========================================================
  // millisecond tick
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick;

  assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));

  always_comb begin
    tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // ==========================================================
  // hold-off state machine
  lshf_state_e st_q, st_d;
  logic [DELAY_W-1:0] ms_q, ms_d;
  logic rep_q, rep_d;
  logic ntf_q, ntf_d;
  logic link_eff;

  // absence is reported by its own path, never delayed
  assign link_eff = link_s & ~sai_s;

  always_comb begin
    st_d = st_q;
    ms_d = ms_q;
    rep_d = rep_q;
    ntf_d = 1'b0;
    case (st_q)
      LSHF_STABLE: begin
        if (sai_s && rep_q) begin
          rep_d = 1'b0;
          ntf_d = 1'b1;
        end else if (link_eff && !rep_q) begin
          if (up_q == '0) begin
            rep_d = 1'b1;
            ntf_d = 1'b1;
          end else begin
            st_d = LSHF_HOLD_UP;
            ms_d = up_q;
          end
        end else if (!link_eff && rep_q) begin
          if (down_q == '0) begin
            rep_d = 1'b0;
            ntf_d = 1'b1;
          end else begin
            st_d = LSHF_HOLD_DOWN;
            ms_d = down_q;
          end
        end
      end
      LSHF_HOLD_UP, LSHF_HOLD_DOWN: begin
        // the reported value changes here only on absence or when the count expires
        if (sai_s) begin
          st_d = LSHF_STABLE;
          rep_d = 1'b0;
          ntf_d = rep_q;
        end else if (link_eff == rep_q) begin
          st_d = LSHF_STABLE;
        end else if (tick) begin
          if (ms_q == 16'h0001) begin
            st_d = LSHF_STABLE;
            rep_d = ~rep_q;
            ntf_d = 1'b1;
          end
          ms_d = ms_q - 16'h0001;
        end
      end
      default: begin
        st_d = LSHF_STABLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= LSHF_STABLE;
      ms_q <= 16'h0000;
      rep_q <= 1'b0;
      ntf_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ms_q <= ms_d;
      rep_q <= rep_d;
      ntf_q <= ntf_d;
    end
  end

  assign link_state = rep_q;
  assign link_notify = ntf_q;

  // ==========================================================
  // checks
  property p_hold_stable;
    @(posedge clk_sys) disable iff (rst)
    (st_q != LSHF_STABLE && !sai_s && st_d != LSHF_STABLE)
      |=> $stable(link_state);
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("reported state moved while hold-off ran");

  property p_up_start;
    @(posedge clk_sys) disable iff (rst)
    (st_q == LSHF_STABLE && link_eff && !rep_q && up_q != '0)
      |=> (st_q == LSHF_HOLD_UP && ms_q == $past(up_q));
  endproperty
  a_up_start: assert property (p_up_start)
    else $error("up hold-off did not start");

  // absence takes the direct path, so it is kept out of the hold entry
  property p_down_start;
    @(posedge clk_sys) disable iff (rst)
    (st_q == LSHF_STABLE && !sai_s && !link_eff && rep_q && down_q != '0)
      |=> (st_q == LSHF_HOLD_DOWN && ms_q == $past(down_q));
  endproperty
  a_down_start: assert property (p_down_start)
    else $error("down hold-off did not start");

  property p_down_now;
    @(posedge clk_sys) disable iff (rst)
    (st_q == LSHF_STABLE && !link_eff && rep_q && down_q == '0)
      |=> (!link_state && link_notify);
  endproperty
  a_down_now: assert property (p_down_now)
    else $error("zero down delay not immediate");

  property p_cfg_default;
    @(posedge clk_sys) disable iff (rst)
    (cfg_wr && !cfg_down_valid) |=> (down_delay == DOWN_DELAY_RST);
  endproperty
  a_cfg_default: assert property (p_cfg_default)
    else $error("omitted down delay kept old value");

  property p_cfg_up;
    @(posedge clk_sys) disable iff (rst)
    (cfg_wr && cfg_up_valid) |=> (up_delay == $past(cfg_up_ms));
  endproperty
  a_cfg_up: assert property (p_cfg_up)
    else $error("up delay not taken");

  // one edge after absence is seen the reported state is already low
  property p_absence;
    @(posedge clk_sys) disable iff (rst)
    sai_s |=> !link_state;
  endproperty
  a_absence: assert property (p_absence)
    else $error("signal absence not reported at once");

  property p_cancel;
    @(posedge clk_sys) disable iff (rst)
    (st_q != LSHF_STABLE && !sai_s && link_eff == rep_q)
      |=> (st_q == LSHF_STABLE && !link_notify && $stable(link_state));
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("cancelled hold-off notified");

  property p_notify_change;
    @(posedge clk_sys) disable iff (rst)
    link_notify |-> (link_state != $past(link_state));
  endproperty
  a_notify_change: assert property (p_notify_change)
    else $error("notification without state change");

  property p_reset_default;
    @(posedge clk_sys)
    rst |=> (up_delay == UP_DELAY_RST && down_delay == DOWN_DELAY_RST);
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("reset delays wrong");
endmodule // lshf_filter
`default_nettype wire

// File: tb/lshf_link_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// raw link detector: level moves on a clock edge
module lshf_link_model (
  // clock
  input wire logic clk_sys,
  // wanted link level
  input wire logic want_up,
  // raw link pin
  output logic link_raw
);
  initial link_raw = 1'b0;
  // registered so the pin never moves mid-cycle
  // plain always: the initial value above is a second writer
  always @(posedge clk_sys) begin
    link_raw <= want_up;
  end
endmodule // lshf_link_model
`default_nettype wire

// File: tb/tb_link_state_hold_off_filter.sv
`timescale 1ns/10ps
`default_nettype none
module tb_link_state_hold_off_filter;
  import lshf_pkg::*;
  // short tick keeps the 200 ms default affordable
  localparam int TC = 4;
  logic clk_sys = 0, rst = 1, want_up = 0, sai = 0, cfg_wr = 0;
  logic uv = 0, dv = 0, link_raw, link_state, link_notify, seen;
  logic [15:0] um = 16'h0000, dm = 16'h0000, up_delay, down_delay;
  int failures = 0, n_checks = 0, n;
  always #50 clk_sys = ~clk_sys;
  lshf_link_model u_lm (.clk_sys(clk_sys), .want_up(want_up),
    .link_raw(link_raw));
  lshf_filter #(.TICK_CYC(TC)) DUT (.clk_sys(clk_sys), .rst(rst),
    .link_raw(link_raw), .signal_absence_indication(sai), .cfg_wr(cfg_wr),
    .cfg_up_valid(uv), .cfg_up_ms(um), .cfg_down_valid(dv),
    .cfg_down_ms(dm), .link_state(link_state), .link_notify(link_notify),
    .up_delay(up_delay), .down_delay(down_delay));
  // ==========================================
  // helpers
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic cfg(input logic u, input logic [15:0] a, input logic d,
      input logic [15:0] b);
    uv = u;
    um = a;
    dv = d;
    dm = b;
    cfg_wr = 1;
    step(1);
    cfg_wr = 0;
    step(1);
  endtask
  // bounded wait; n counts cycles taken
  task automatic wait_st(input logic v, input int k);
    n = 0;
    while (link_state !== v && n < k) begin
      step(1);
      n++;
    end
    if (link_state !== v) begin
      failures++;
      give_verdict();
    end
    chk({15'h0000, link_notify}, 16'h0001);
  endtask
  task automatic rng(input int lo, input int hi);
    chk({15'h0000, (n >= lo && n <= hi)}, 16'h0001);
  endtask
  // quiet window: no state change and no pulse allowed
  task automatic quiet(input logic v, input int k);
    seen = 0;
    repeat (k) begin
      step(1);
      seen = seen | link_notify | (link_state !== v);
    end
    chk({15'h0000, seen}, 16'h0000);
  endtask
  // ==========================================
  // scenarios
  task automatic sc_reset_defaults();
    step(2);
    rst = 0;
    chk(up_delay, 16'(UP_DELAY_DEF_MS));
    chk(down_delay, 16'(DOWN_DELAY_DEF_MS));
  endtask
  task automatic sc_default_delays();
    want_up = 1;
    wait_st(1, 900);
    rng(800, 806);
    want_up = 0;
    wait_st(0, 10);
    chk(n[15:0], 16'h0004);
  endtask
  task automatic sc_cfg_pairs();
    cfg(0, 16'h0009, 1, 16'h0005);
    chk(up_delay, 16'(UP_DELAY_DEF_MS));
    chk(down_delay, 16'h0005);
    cfg(1, 16'h0003, 0, 16'h0007);
    chk(up_delay, 16'h0003);
    chk(down_delay, 16'(DOWN_DELAY_DEF_MS));
  endtask
  // leaves the link reported up with a 5 ms down delay
  task automatic sc_absence();
    cfg(1, 16'h0000, 1, 16'h0005);
    want_up = 1;
    wait_st(1, 10);
    sai = 1;
    wait_st(0, 6);
    quiet(0, 20);
    sai = 0;
    wait_st(1, 10);
  endtask
  task automatic sc_down_hold();
    want_up = 0;
    wait_st(0, 40);
    rng(20, 26);
  endtask
  task automatic sc_cancel();
    cfg(1, 16'h0003, 1, 16'h0005);
    want_up = 1;
    step(6);
    want_up = 0;
    quiet(0, 30);
  endtask
  initial begin
    sc_reset_defaults();
    sc_default_delays();
    sc_cfg_pairs();
    sc_absence();
    sc_down_hold();
    sc_cancel();
    give_verdict();
  end
endmodule // tb_link_state_hold_off_filter
`default_nettype wire
